// ==== hdl/icd_pkg.sv ====
// Purpose : Constants, field layouts and modes of the input capture unit
// Assumes : One aligned 32-bit word per register, 16 data bits in the low half
// Notes   : Shared by the design and the bench
`default_nettype none
package icd_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [11:0] ADDR_CTRL_ONE = 12'h000;
   localparam logic [11:0] ADDR_CTRL_TWO = 12'h004;
   localparam logic [11:0] ADDR_BUFFER   = 12'h008;
   localparam logic [11:0] ADDR_COUNTER  = 12'h00c;

   // ==========================================================
   // Field layouts
   typedef struct packed {
      logic [1:0] rsv_hi;
      logic       idle_stop;
      logic [2:0] timebase_select;
      logic [2:0] rsv_mid;
      logic [1:0] captures_per_interrupt;
      logic       capture_overflow_flag;
      logic       buffer_not_empty;
      logic [2:0] capture_mode_select;
   } icd_ctrl_one_t;

   typedef struct packed {
      logic [6:0] rsv_hi;
      logic       cascade_enable;
      logic       trigger_mode_select;
      logic       trigger_armed_status;
      logic       rsv_lo;
      logic [4:0] sync_source_select;
   } icd_ctrl_two_t;

   // ==========================================================
   // Reset values
   localparam logic [15:0] CTRL_ONE_RST = 16'h0000;
   localparam logic [15:0] CTRL_TWO_RST = 16'h000d;

   // ==========================================================
   // Capture modes
   typedef enum logic [2:0] {
      MODE_OFF    = 3'h0,
      MODE_BOTH   = 3'h1,
      MODE_FALL   = 3'h2,
      MODE_RISE   = 3'h3,
      MODE_DIV4   = 3'h4,
      MODE_DIV16  = 3'h5,
      MODE_UNUSED = 3'h6,
      MODE_WAKE   = 3'h7
   } icd_mode_t;

   // ==========================================================
   // Timebase codes, sync, fifo, bus
   localparam logic [2:0] TB_SYS    = 3'h7;
   localparam logic [2:0] TB_TMR1   = 3'h4;
   localparam logic [2:0] TB_TMR2   = 3'h1;
   localparam logic [2:0] TB_TMR3   = 3'h0;
   localparam logic [4:0] SYNC_OFF  = 5'h00;
   localparam logic [2:0] FIFO_DEPTH = 3'h4;
   localparam logic [3:0] PRESC_DIV4  = 4'h3;
   localparam logic [3:0] PRESC_DIV16 = 4'hf;
   localparam logic [15:0] CNT_MAX  = 16'hffff;
   localparam logic        RESP_OKAY = 1'b0;

endpackage
`default_nettype wire

// ==== hdl/icd_capture_unit.sv ====
// Purpose : Input capture unit with dedicated 16-bit counter and 4-entry FIFO,
//           registers reached over AHB-Lite
// Assumes : All inputs synchronous to hclk; sync_events are one-cycle pulses
// Notes   : Summary of operation below
//
// Summary of operation
// R1 - Free-running counter counts up, wraps from all ones to zero, no reload.
// R2 - Each qualifying capture event pushes the present counter value into the FIFO.
// R3 - FIFO holds up to four captured values.
// R4 - Sync mode: capture runs once clocked; sync source event clears counter.
// R5 - Trigger mode: counter stopped until a selected sync event arrives.
// R6 - Source zero and trigger clear is free-running; nonzero source selects sync/trigger.
// R7 - Source zero with trigger set: captures start after software sets armed bit.
// R8 - Cascade: odd unit is low half, even unit high; low rollover increments high.
// R9 - Cascade active only when cascade bit set in both paired units.
// R10 - Even unit with trigger clear runs synchronously with the odd unit.
// R11 - Cascaded sync operation holds both units in reset until sync source fires.
// R12 - Read-only buffer-not-empty flag set while FIFO holds a value.
// R13 - Software reads odd buffer for low word, even buffer for high word.
// R14 - Timebase select: 111 system, 100 timer one, 001 timer two, 000 timer three.
// R15 - Interrupt after every first, second, third or fourth capture.
// R16 - Read-only overflow flag set by hardware when a capture finds FIFO full.
// R17 - Mode 000 off, 001 both edges, 010 falling, 011 rising; 001 ignores rate.
// R18 - Mode 100 every fourth rise, 101 every sixteenth rise, 110 disabled.
// R19 - Mode 111: input is only a rising-edge wake interrupt during sleep or idle.
// R20 - Idle stop bit set halts the unit while the processor idles.
// R21 - Software drains FIFO, configures, and enables the sync source last.
// R22 - Cascade set up even unit first with identical timebase and source.
// R23 - Armed bit set by trigger hardware or software; clear holds counter at zero.
// R24 - Each buffer read returns the oldest value and removes it.
`timescale 1ns/1ps
`default_nettype none
module icd_capture_unit #(
   parameter logic IS_UPPER = 1'b0
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Capture pin and system events
   input  wire logic        capture_input,
   input  wire logic [31:0] sync_events,
   input  wire logic [2:0]  timer_ticks,
   input  wire logic        cpu_idle,
   input  wire logic        cpu_sleep,
   // Cascade partner
   input  wire logic        paired_cascade_in,
   input  wire logic        paired_rollover_in,
   input  wire logic        paired_capture_in,
   output logic             cascade_out,
   output logic             rollover_out,
   output logic             capture_strobe_out,
   // Interrupt request
   output logic             capture_irq
);

   // ==========================================================
   // Declarations
   icd_pkg::icd_ctrl_one_t c1_q;
   icd_pkg::icd_ctrl_two_t c2_q;
   icd_pkg::icd_mode_t     mode;
   logic [15:0] cnt_q;
   logic [15:0] mem_q [4];
   logic [1:0]  wr_ptr_q;
   logic [1:0]  rd_ptr_q;
   logic [2:0]  fill_q;
   logic        ovf_q;
   logic        armed_q;
   logic        sync_seen_q;
   logic        in_prev_q;
   logic [3:0]  presc_q;
   logic [1:0]  ipc_q;
   logic        wr_pend_q;
   logic [11:0] wr_addr_q;
   logic        hreadyout_q;
   logic        hresp_q;
   logic [31:0] hrdata_q;
   logic        irq_q;
   logic        roll_q;
   logic        strobe_q;
   logic        addr_ok;
   logic        rd_buf;
   logic        pop;
   logic        push;
   logic        full;
   logic        unit_on;
   logic        halted;
   logic        active;
   logic        casc;
   logic        upper_slave;
   logic        trig_mode;
   logic        sync_hit;
   logic        sync_clr;
   logic        hold_zero;
   logic        tick;
   logic        inc;
   logic        rise;
   logic        fall;
   logic        cap_ev;
   logic        cap;
   logic        wr_c1;
   logic        wr_c2;
   logic [31:0] rd_word;
   logic [15:0] c1_view;

   // ==========================================================
   // Bus decode
   assign addr_ok = hsel & htrans[1] & hready;
   assign rd_buf  = addr_ok & ~hwrite & (haddr[11:0] == icd_pkg::ADDR_BUFFER);
   assign pop     = rd_buf & (fill_q != 3'h0); // [R24]
   assign wr_c1   = wr_pend_q & (wr_addr_q == icd_pkg::ADDR_CTRL_ONE);
   assign wr_c2   = wr_pend_q & (wr_addr_q == icd_pkg::ADDR_CTRL_TWO);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
      end else if (hready) begin
         wr_pend_q <= addr_ok & hwrite;
         wr_addr_q <= haddr[11:0];
      end
   end

   // Status bits are merged into the control view on read
   always_comb begin
      c1_view = c1_q;
      c1_view[4] = ovf_q;                 // [R16]
      c1_view[3] = (fill_q != 3'h0);      // [R12]
      rd_word = 32'h0000_0000;
      case (haddr[11:0])
         icd_pkg::ADDR_CTRL_ONE: rd_word = {16'h0000, c1_view};
         icd_pkg::ADDR_CTRL_TWO: rd_word = {16'h0000, c2_q[15:7], armed_q, c2_q[5:0]}; // [R23]
         icd_pkg::ADDR_BUFFER:   rd_word = {16'h0000, mem_q[rd_ptr_q]}; // [R13]
         icd_pkg::ADDR_COUNTER:  rd_word = {16'h0000, cnt_q};
         default:                rd_word = 32'h0000_0000;
      endcase
   end

   // Zero wait state; read data latched at the end of the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b0;
         hresp_q     <= icd_pkg::RESP_OKAY;
         hrdata_q    <= 32'h0000_0000;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q     <= icd_pkg::RESP_OKAY;
         if (addr_ok && !hwrite) begin
            hrdata_q <= rd_word;
         end
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         c1_q <= icd_pkg::CTRL_ONE_RST;
      end else if (wr_c1) begin
         c1_q.idle_stop              <= hwdata[13];
         c1_q.timebase_select        <= hwdata[12:10];
         c1_q.captures_per_interrupt <= hwdata[6:5];
         c1_q.capture_mode_select    <= hwdata[2:0];
      end
   end

   // Armed bit: hardware set wins over a software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         c2_q <= icd_pkg::CTRL_TWO_RST;
      end else if (wr_c2) begin
         c2_q.cascade_enable      <= hwdata[8];
         c2_q.trigger_mode_select <= hwdata[7];
         c2_q.sync_source_select  <= hwdata[4:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         armed_q <= 1'b0;
      end else if (trig_mode && sync_hit) begin
         armed_q <= 1'b1; // [R23]
      end else if (wr_c2) begin
         armed_q <= hwdata[6]; // [R7] [R23]
      end
   end

   // ==========================================================
   // Mode decode
   assign mode        = icd_pkg::icd_mode_t'(c1_q.capture_mode_select);
   assign unit_on     = (mode != icd_pkg::MODE_OFF) && (mode != icd_pkg::MODE_UNUSED)
                        && (mode != icd_pkg::MODE_WAKE); // [R17] [R18] [R19]
   assign halted      = c1_q.idle_stop & cpu_idle; // [R20]
   assign active      = unit_on & ~halted;
   assign casc        = c2_q.cascade_enable & paired_cascade_in; // [R9]
   assign upper_slave = casc & IS_UPPER;
   // Upper unit with trigger bit clear follows the lower unit synchronously
   assign trig_mode   = c2_q.trigger_mode_select; // [R10]
   assign sync_hit    = (c2_q.sync_source_select != icd_pkg::SYNC_OFF)
                        & sync_events[c2_q.sync_source_select]; // [R6]
   assign sync_clr    = ~trig_mode & sync_hit; // [R4]
   assign hold_zero   = (trig_mode & ~armed_q) // [R5]
                        | (casc & ~trig_mode & (c2_q.sync_source_select != icd_pkg::SYNC_OFF)
                           & ~sync_seen_q); // [R11]

   // Pair starts in unison only when software follows the ordered setup [R21] [R22]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_seen_q <= 1'b0;
      end else if (sync_hit) begin
         sync_seen_q <= 1'b1;
      end else if (!unit_on) begin
         sync_seen_q <= 1'b0;
      end
   end

   // ==========================================================
   // Timebase and counter
   always_comb begin
      case (c1_q.timebase_select) // [R14]
         icd_pkg::TB_SYS:  tick = 1'b1;
         icd_pkg::TB_TMR1: tick = timer_ticks[0];
         icd_pkg::TB_TMR2: tick = timer_ticks[1];
         icd_pkg::TB_TMR3: tick = timer_ticks[2];
         default:          tick = 1'b0;
      endcase
   end

   assign inc = upper_slave ? paired_rollover_in : tick; // [R8]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 16'h0000;
      end else if (!unit_on || hold_zero) begin
         cnt_q <= 16'h0000; // [R5] [R23]
      end else if (halted) begin
         cnt_q <= cnt_q; // [R20]
      end else if (sync_clr) begin
         cnt_q <= 16'h0000; // [R4]
      end else if (inc) begin
         cnt_q <= cnt_q + 16'h0001; // [R1]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         roll_q <= 1'b0;
      end else begin
         roll_q <= active & ~hold_zero & ~sync_clr & inc & (cnt_q == icd_pkg::CNT_MAX); // [R8]
      end
   end

   // ==========================================================
   // Edge detection and prescaler
   assign rise = capture_input & ~in_prev_q;
   assign fall = ~capture_input & in_prev_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_prev_q <= 1'b0;
      end else begin
         in_prev_q <= capture_input;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc_q <= 4'h0;
      end else if (mode != icd_pkg::MODE_DIV4 && mode != icd_pkg::MODE_DIV16) begin
         presc_q <= 4'h0;
      end else if (active && rise) begin
         presc_q <= (mode == icd_pkg::MODE_DIV4 && presc_q == icd_pkg::PRESC_DIV4)
                    ? 4'h0 : presc_q + 4'h1; // [R18]
      end
   end

   always_comb begin
      case (mode) // [R17] [R18]
         icd_pkg::MODE_BOTH:  cap_ev = rise | fall;
         icd_pkg::MODE_FALL:  cap_ev = fall;
         icd_pkg::MODE_RISE:  cap_ev = rise;
         icd_pkg::MODE_DIV4:  cap_ev = rise & (presc_q == icd_pkg::PRESC_DIV4);
         icd_pkg::MODE_DIV16: cap_ev = rise & (presc_q == icd_pkg::PRESC_DIV16);
         default:             cap_ev = 1'b0;
      endcase
   end

   // Upper unit captures on the lower unit's strobe
   assign cap  = upper_slave ? paired_capture_in
                 : (cap_ev & active & ~hold_zero); // [R7] [R2]
   assign full = (fill_q == icd_pkg::FIFO_DEPTH);
   assign push = cap & (~full | pop); // [R3]

   // ==========================================================
   // Capture FIFO
   generate
      for (genvar i = 0; i < 4; i++) begin : g_entry
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               mem_q[i] <= 16'h0000;
            end else if (push && wr_ptr_q == 2'(i)) begin
               mem_q[i] <= cnt_q; // [R2]
            end
         end
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ptr_q <= 2'h0;
         rd_ptr_q <= 2'h0;
         fill_q   <= 3'h0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 2'h1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 2'h1; // [R24]
         end
         if (push && !pop) begin
            fill_q <= fill_q + 3'h1; // [R3]
         end else if (pop && !push) begin
            fill_q <= fill_q - 3'h1; // [R12]
         end
      end
   end

   // Overflow set wins; cleared only by selecting mode 000 (off), not by modes 110 or 111
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovf_q <= 1'b0;
      end else if (cap && full && !pop) begin
         ovf_q <= 1'b1; // [R16]
      end else if (mode == icd_pkg::MODE_OFF) begin
         ovf_q <= 1'b0;
      end
   end

   // ==========================================================
   // Interrupt rate and outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ipc_q <= 2'h0;
         irq_q <= 1'b0;
      end else begin
         irq_q <= 1'b0;
         if (mode == icd_pkg::MODE_WAKE) begin
            ipc_q <= 2'h0;
            irq_q <= rise & (cpu_sleep | cpu_idle); // [R19]
         end else if (!unit_on) begin
            ipc_q <= 2'h0;
         end else if (cap && !upper_slave) begin
            if (mode == icd_pkg::MODE_BOTH) begin
               irq_q <= 1'b1; // [R17]
            end else if (ipc_q == c1_q.captures_per_interrupt) begin
               ipc_q <= 2'h0;
               irq_q <= 1'b1; // [R15]
            end else begin
               ipc_q <= ipc_q + 2'h1;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strobe_q <= 1'b0;
      end else begin
         strobe_q <= cap & ~upper_slave;
      end
   end

   assign hreadyout          = hreadyout_q;
   assign hresp              = hresp_q;
   assign hrdata             = hrdata_q;
   assign capture_irq        = irq_q;
   assign rollover_out       = roll_q;
   assign capture_strobe_out = strobe_q;
   assign cascade_out        = c2_q.cascade_enable;

   // ==========================================================
   // Assertions
   property p_wrap;
      @(posedge hclk) disable iff (!hresetn)
      (active && !hold_zero && !sync_clr && inc && cnt_q == icd_pkg::CNT_MAX)
      |=> (cnt_q == 16'h0000) && rollover_out;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // [R1]

   property p_push;
      @(posedge hclk) disable iff (!hresetn)
      (push && !pop) |=> (fill_q == $past(fill_q) + 3'h1) && (mem_q[$past(wr_ptr_q)] == $past(cnt_q));
   endproperty
   a_push: assert property (p_push) else $error("capture not stored"); // [R2]

   property p_depth;
      @(posedge hclk) disable iff (!hresetn)
      full && cap && !pop |=> full && ovf_q;
   endproperty
   a_depth: assert property (p_depth) else $error("full fifo mishandled"); // [R3]

   property p_sync;
      @(posedge hclk) disable iff (!hresetn)
      (unit_on && !hold_zero && !halted && sync_clr) |=> cnt_q == 16'h0000;
   endproperty
   a_sync: assert property (p_sync) else $error("sync did not clear counter"); // [R4]

   property p_trig_hold;
      @(posedge hclk) disable iff (!hresetn)
      (trig_mode && !armed_q && !(wr_c2 && hwdata[6]) && !sync_hit)[*2] |=> cnt_q == 16'h0000;
   endproperty
   a_trig_hold: assert property (p_trig_hold) else $error("counter ran unarmed"); // [R5]

   property p_pop;
      @(posedge hclk) disable iff (!hresetn)
      (pop && !push) |=> (fill_q == $past(fill_q) - 3'h1) && (hrdata == $past(mem_q[rd_ptr_q]));
   endproperty
   a_pop: assert property (p_pop) else $error("buffer read wrong"); // [R24]

   property p_rate;
      @(posedge hclk) disable iff (!hresetn)
      (cap && !upper_slave && unit_on && mode != icd_pkg::MODE_BOTH
       && ipc_q != c1_q.captures_per_interrupt) |=> !capture_irq;
   endproperty
   a_rate: assert property (p_rate) else $error("early interrupt"); // [R15]

   property p_off;
      @(posedge hclk) disable iff (!hresetn)
      (mode == icd_pkg::MODE_OFF) [*2] |-> (cnt_q == 16'h0000) && !capture_strobe_out;
   endproperty
   a_off: assert property (p_off) else $error("unit active while off"); // [R17]

   property p_idle;
      @(posedge hclk) disable iff (!hresetn)
      (unit_on && !hold_zero && halted) |=> cnt_q == $past(cnt_q);
   endproperty
   a_idle: assert property (p_idle) else $error("counter moved in idle"); // [R20]

   property p_cascade;
      @(posedge hclk) disable iff (!hresetn)
      (upper_slave && active && !hold_zero && !sync_clr && paired_rollover_in)
      |=> cnt_q == $past(cnt_q) + 16'h0001;
   endproperty
   a_cascade: assert property (p_cascade) else $error("upper half missed carry"); // [R8]

   c_full:  cover property (@(posedge hclk) disable iff (!hresetn) full);
   c_ovf:   cover property (@(posedge hclk) disable iff (!hresetn) $rose(ovf_q));
   c_irq:   cover property (@(posedge hclk) disable iff (!hresetn) capture_irq);
   c_carry: cover property (@(posedge hclk) disable iff (!hresetn) upper_slave && paired_rollover_in);

endmodule
`default_nettype wire

// ==== tb/icd_pulse_src.sv ====
// Purpose : Far-side model: capture pin, sync event pulses, timer ticks
// Assumes : Tasks are called from the bench right after a rising edge
// Notes   : Sync events last one cycle, ticks one cycle each
`timescale 1ns/1ps
`default_nettype none
module icd_pulse_src (
   // Clock
   input  wire logic        hclk,
   // Far-side signals
   output logic             capture_input,
   output logic [31:0]      sync_events,
   output logic [2:0]       timer_ticks
);
   // ==========================================
   // Idle levels
   initial begin
      capture_input = 1'b0;
      sync_events   = 32'h0;
      timer_ticks   = 3'h0;
   end

   // ==========================================
   // Stimulus tasks
   // Pin high for hi cycles, then low
   task automatic edge_pair(input int hi);
      @(posedge hclk) capture_input <= 1'b1;
      repeat (hi) @(posedge hclk);
      capture_input <= 1'b0;
   endtask

   // One-cycle event on a source code
   task automatic sync_pulse(input logic [4:0] code);
      @(posedge hclk) sync_events <= 32'h1 << code;
      @(posedge hclk) sync_events <= 32'h0;
   endtask

   task automatic tick(input logic [2:0] t);
      @(posedge hclk) timer_ticks <= t;
      @(posedge hclk) timer_ticks <= 3'h0;
   endtask
endmodule
`default_nettype wire

// ==== tb/input_capture_dedicated_timer_tb.sv ====
// Purpose : Self-checking bench of one capture unit, no cascade partner
// Assumes : Registers reached over AHB-Lite, zero wait states
// Notes   : Expectations from edge spacing and field codes
`timescale 1ns/1ps
`default_nettype none
module input_capture_dedicated_timer_tb;
   // ==========================================
   // Signals
   localparam logic [11:0] A1 = icd_pkg::ADDR_CTRL_ONE;
   localparam logic [11:0] A2 = icd_pkg::ADDR_CTRL_TWO;
   localparam logic [11:0] AB = icd_pkg::ADDR_BUFFER;
   localparam logic [11:0] AC = icd_pkg::ADDR_COUNTER;
   logic        hclk, hresetn, hsel, hwrite, cpu_idle, hreadyout, hresp, cap_in, irq;
   logic        cpu_sleep, pair_casc, casc_o, roll_o, stb_o;
   logic [1:0]  htrans;
   logic [2:0]  hsize, ticks;
   logic [31:0] haddr, hwdata, hrdata, sync_ev, rd, c0;
   logic [15:0] cfg [8];
   logic [7:0]  bne_exp;
   int          num_errors, n_compared, cyc, n_irq, n_stb, n_roll;

   icd_capture_unit #(.IS_UPPER(1'b0)) dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .capture_input(cap_in),
      .sync_events(sync_ev), .timer_ticks(ticks), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
      .paired_cascade_in(pair_casc), .paired_rollover_in(1'b0), .paired_capture_in(1'b0),
      .cascade_out(casc_o), .rollover_out(roll_o), .capture_strobe_out(stb_o), .capture_irq(irq));

   icd_pulse_src src_u (.hclk(hclk), .capture_input(cap_in), .sync_events(sync_ev),
      .timer_ticks(ticks));

   // ==========================================
   // Clock, watchdog, interrupt counter
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cyc++;
      if (irq === 1'b1) n_irq++;
      if (stb_o === 1'b1) n_stb++;
      if (roll_o === 1'b1) n_roll++;
      if (cyc == 80000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // ==========================================
   // Shared tasks
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {20'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset();
      bus(1'b0, A1, 32'h0);
      check("ctrl_one_rst", rd, 32'h0000);
      bus(1'b0, A2, 32'h0);
      check("ctrl_two_rst", rd, 32'h000d);
      bus(1'b1, 12'h010, 32'hffff);
      bus(1'b0, 12'h010, 32'h0);
      check("unmapped", rd, 32'h0);
      bus(1'b1, A2, 32'h0);
   endtask

   task automatic t_modes();
      for (int i = 0; i < 8; i++) begin
         cpu_idle <= cfg[i][13];
         bus(1'b1, A1, {16'h0, cfg[i]});
         src_u.edge_pair(3);
         repeat (3) @(posedge hclk);
         bus(1'b0, A1, 32'h0);
         check("mode_bne", {31'h0, rd[3]}, {31'h0, bne_exp[i]});
         bus(1'b0, AB, 32'h0);
         bus(1'b0, AB, 32'h0);
         bus(1'b1, A1, 32'h0);
      end
      cpu_idle <= 1'b0;
   endtask

   task automatic t_fifo();
      bus(1'b1, A1, 32'h1c03);
      repeat (5) src_u.edge_pair(3);
      repeat (3) @(posedge hclk);
      bus(1'b0, A1, 32'h0);
      check("ctrl_one_full", rd, 32'h1c1b);
      bus(1'b0, AB, 32'h0);
      c0 = rd;
      for (int i = 1; i < 4; i++) begin
         bus(1'b0, AB, 32'h0);
         check("capture_step", rd, c0 + 32'(4 * i));
      end
      bus(1'b0, A1, 32'h0);
      check("ctrl_one_empty", rd, 32'h1c13);
      bus(1'b1, A1, 32'h0);
   endtask

   task automatic t_irq();
      bus(1'b1, A1, 32'h1c63);
      n_irq = 0;
      repeat (4) src_u.edge_pair(3);
      repeat (3) @(posedge hclk);
      check("irq_fourth", 32'(n_irq), 32'h1);
      repeat (4) bus(1'b0, AB, 32'h0);
      bus(1'b1, A1, 32'h0);
      bus(1'b1, A1, 32'h1c61);
      n_irq = 0;
      src_u.edge_pair(3);
      repeat (3) @(posedge hclk);
      check("irq_both", 32'(n_irq), 32'h2);
      repeat (2) bus(1'b0, AB, 32'h0);
   endtask

   task automatic t_sync_trig();
      bus(1'b1, A1, 32'h1c03);
      bus(1'b1, A2, 32'h0005);
      repeat (30) @(posedge hclk);
      bus(1'b0, AC, 32'h0);
      check("sync_running", {31'h0, rd > 32'd20}, 32'h1);
      src_u.sync_pulse(5'h05);
      bus(1'b0, AC, 32'h0);
      check("sync_cleared", {31'h0, rd < 32'd5}, 32'h1);
      bus(1'b1, A2, 32'h0085);
      repeat (5) @(posedge hclk);
      bus(1'b0, AC, 32'h0);
      check("trig_held", rd, 32'h0);
      src_u.sync_pulse(5'h05);
      bus(1'b0, A2, 32'h0);
      check("trig_armed", rd, 32'h00c5);
      bus(1'b0, AC, 32'h0);
      check("trig_runs", {31'h0, rd != 32'h0}, 32'h1);
      bus(1'b1, A2, 32'h0080);
      src_u.sync_pulse(5'h05);
      bus(1'b0, AC, 32'h0);
      check("swtrig_held", rd, 32'h0);
      bus(1'b1, A2, 32'h00c0);
      repeat (3) @(posedge hclk);
      bus(1'b0, AC, 32'h0);
      check("swtrig_runs", {31'h0, rd != 32'h0}, 32'h1);
   endtask

   task automatic t_timebase();
      bus(1'b1, A2, 32'h0);
      bus(1'b1, A1, 32'h1003);
      bus(1'b0, AC, 32'h0);
      c0 = rd;
      src_u.tick(3'h6);
      repeat (3) src_u.tick(3'h1);
      bus(1'b0, AC, 32'h0);
      check("tb_timer_one", rd, c0 + 32'h3);
      bus(1'b1, A1, 32'h1803);
      bus(1'b0, AC, 32'h0);
      c0 = rd;
      src_u.tick(3'h7);
      bus(1'b0, AC, 32'h0);
      check("tb_reserved", rd, c0);
   endtask

   task automatic t_pair();
      bus(1'b1, A1, 32'h7);
      cpu_sleep <= 1'b1;
      n_irq = 0;
      src_u.edge_pair(3);
      check("wake_irq", 32'(n_irq), 32'h1);
      pair_casc <= 1'b1;
      bus(1'b1, A1, 32'h0);
      bus(1'b1, A2, 32'h0105);
      bus(1'b1, A1, 32'h1c03);
      check("casc_out", {31'h0, casc_o}, 32'h1);
      bus(1'b0, AC, 32'h0);
      check("casc_held", rd, 32'h0);
      src_u.sync_pulse(5'h05);
      n_stb = 0;
      src_u.edge_pair(3);
      check("strobe", 32'(n_stb), 32'h1);
      bus(1'b0, AB, 32'h0);
      check("casc_runs", {31'h0, rd != 32'h0}, 32'h1);
      n_roll = 0;
      repeat (65536) @(posedge hclk);
      check("rollover", 32'(n_roll), 32'h1);
   endtask

   // ==========================================
   // Main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      cpu_idle = 1'b0;
      cpu_sleep = 1'b0;
      pair_casc = 1'b0;
      num_errors = 0;
      n_compared = 0;
      cyc = 0;
      n_irq = 0;
      for (int i = 0; i < 7; i++) cfg[i] = 16'h1c00 | 16'(i);
      cfg[7] = 16'h3c03;
      bne_exp = 8'h0e;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      t_reset();
      t_modes();
      t_fifo();
      t_irq();
      t_sync_trig();
      t_timebase();
      t_pair();
      report_and_stop();
   end
endmodule
`default_nettype wire
